// ==== logic/slc_lof_top.sv ====
`timescale 1ns/100ps
module slc_lof_top #(
    parameter int LOF_DECL_CYC = slc_pkg::LOF_DECL_CYCLES
) (
    input wire logic REF_CLK_IN,
    input wire logic NRST_IN,
    input wire logic FRAME_START_IN,
    input wire logic A1A2_OK_IN,
    input wire logic SEF_IN,
    input wire logic LOS_IN,
    input wire logic RDIL_DEF_IN,
    input wire logic S1_UNSTABLE_IN,
    input wire logic K1K2_UNSTABLE_IN,
    input wire logic SF_IN,
    input wire logic SD_IN,
    input wire logic SF_CHG_IN,
    input wire logic SD_CHG_IN,
    input wire logic REIL_ERR_IN,
    input wire logic B2_ERR_IN,
    input wire logic B1_ERR_IN,
    input wire logic SEF_CHG_IN,
    input wire logic LOS_CHG_IN,
    input wire logic [slc_pkg::DATA_W-1:0] INT_EN_IN,
    input wire logic UP_CS_N_IN,
    input wire logic UP_RD_N_IN,
    input wire logic UP_WR_N_IN,
    input wire logic [slc_pkg::ADDR_W-1:0] UP_ADDR_IN,
    input wire logic [slc_pkg::DATA_W-1:0] UP_WDATA_IN,
    output logic [slc_pkg::DATA_W-1:0] UP_RDATA_OUT,
    output logic INT_N_OUT,
    output logic TX_RDIL_OUT,
    output logic LOF_OUT
);
    import slc_pkg::*;

    slc_state_t state_q;
    slc_state_t state_d;
    logic [DECL_CNT_W-1:0] decl_cnt_q;
    logic [DECL_CNT_W-1:0] decl_cnt_d;
    logic [THR_W-1:0] good_cnt_q;
    logic [THR_W-1:0] good_cnt_d;
    logic [THR_W-1:0] good_cnt_inc;
    logic [THR_W-1:0] thr_q;
    logic [CTL_W-1:0] rdil_ctl_q;
    logic [DATA_W-1:0] int_flags;
    logic [DATA_W-1:0] int_ev;
    logic [DATA_W-1:0] status_byte;
    logic [DATA_W-1:0] rdata_d;
    logic in_lof;
    logic in_sef_wait;
    logic decl_done;
    logic clear_ok;
    logic lof_decl_ev;
    logic lof_chg_ev;
    logic rd_stb;
    logic wr_stb;
    logic hit_stat;
    logic hit_int;
    logic hit_thr;
    logic hit_ctl;
    logic rd_int;
    logic rdil_d;
    logic int_n_d;

    default clocking cb @(posedge REF_CLK_IN);
    endclocking
    default disable iff (!NRST_IN);

    // microprocessor strobes and address decode
    assign rd_stb = ~UP_CS_N_IN & ~UP_RD_N_IN;
    assign wr_stb = ~UP_CS_N_IN & ~UP_WR_N_IN;
    assign hit_stat = (UP_ADDR_IN == ADDR_DEFECT_STAT0);
    assign hit_int = (UP_ADDR_IN == ADDR_INT_STAT0);
    assign hit_thr = (UP_ADDR_IN == ADDR_INSYNC_THR);
    assign hit_ctl = (UP_ADDR_IN == ADDR_RDIL_CTRL);
    assign rd_int = rd_stb & hit_int;

    // state decode
    assign in_lof = (state_q == ST_LOF);
    assign in_sef_wait = (state_q == ST_SEF_WAIT);

    // SEF persistence timer; any break in SEF restarts it from zero
    assign decl_done = (decl_cnt_q == DECL_CNT_W'(LOF_DECL_CYC - 1));
    assign decl_cnt_d = (in_sef_wait & SEF_IN) ? decl_cnt_q + 18'h1 : '0;
    assign lof_decl_ev = in_sef_wait & SEF_IN & decl_done;

    // good-frame run: zeroed by SEF or a bad frame, saturates so it never wraps past threshold
    assign good_cnt_inc = (good_cnt_q == GOOD_CNT_MAX) ? good_cnt_q : good_cnt_q + 4'h1;
    assign good_cnt_d = (!in_lof || SEF_IN) ? '0 :
                        FRAME_START_IN ? (A1A2_OK_IN ? good_cnt_inc : '0) : good_cnt_q;
    // a threshold of zero clears as soon as SEF is gone, with no frame needed
    assign clear_ok = in_lof & ~SEF_IN & (good_cnt_q >= thr_q);
    assign lof_chg_ev = lof_decl_ev | clear_ok;

    // framing supervision: in frame, SEF timing, loss of frame
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_INFRAME: if (SEF_IN) state_d = ST_SEF_WAIT;
            ST_SEF_WAIT: begin
                if (!SEF_IN) begin
                    state_d = ST_INFRAME;
                end else if (decl_done) begin
                    state_d = ST_LOF;
                end
            end
            ST_LOF: if (clear_ok) state_d = ST_INFRAME;
            default: state_d = ST_INFRAME;
        endcase
    end

    always_ff @(posedge REF_CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            state_q <= ST_INFRAME;
            decl_cnt_q <= '0;
            good_cnt_q <= '0;
        end else begin
            state_q <= state_d;
            decl_cnt_q <= decl_cnt_d;
            good_cnt_q <= good_cnt_d;
        end
    end

    // software-written configuration; only the low nibbles exist
    always_ff @(posedge REF_CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            thr_q <= THR_RST;
            rdil_ctl_q <= RDIL_CTRL_RST;
        end else begin
            if (wr_stb && hit_thr) thr_q <= UP_WDATA_IN[THR_MSB:0];
            if (wr_stb && hit_ctl) rdil_ctl_q <= UP_WDATA_IN[CTL_W-1:0];
        end
    end

    // interrupt events, one flag per bit; the LOF change comes from this block
    assign int_ev = {SF_CHG_IN, SD_CHG_IN, REIL_ERR_IN, B2_ERR_IN,
                     B1_ERR_IN, lof_chg_ev, SEF_CHG_IN, LOS_CHG_IN};

    genvar gi;
    generate
        for (gi = 0; gi < DATA_W; gi++) begin : g_flag
            slc_rur_flag u_flag (
                .clk_in(REF_CLK_IN),
                .rst_n_in(NRST_IN),
                .set_in(int_ev[gi]),
                .clr_in(rd_int),
                .q_out(int_flags[gi])
            );
        end
    endgenerate

    // defect status is a live view, so it needs no storage of its own
    assign status_byte = {RDIL_DEF_IN, S1_UNSTABLE_IN, K1K2_UNSTABLE_IN, SF_IN,
                          SD_IN, in_lof, SEF_IN, LOS_IN};

    // read mux; unmapped offsets read zero, reserved bits read zero
    assign rdata_d = hit_stat ? status_byte :
                     hit_int ? int_flags :
                     hit_thr ? {{(DATA_W-THR_W){1'b0}}, thr_q} :
                     hit_ctl ? {{(DATA_W-CTL_W){1'b0}}, rdil_ctl_q} : UNMAPPED_DATA;

    // RDI-L follows LOF (and LOS) only while enabled; AIS-L and external sources live elsewhere
    assign rdil_d = (rdil_ctl_q[CTL_RDIL_LOF] & in_lof) |
                    (rdil_ctl_q[CTL_RDIL_LOS] & LOS_IN);
    assign int_n_d = ~|(int_flags & INT_EN_IN);

    // every top output is a flop; read data holds between reads
    always_ff @(posedge REF_CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            UP_RDATA_OUT <= RDATA_RST;
            INT_N_OUT <= 1'b1;
            TX_RDIL_OUT <= 1'b0;
            LOF_OUT <= 1'b0;
        end else begin
            if (rd_stb) UP_RDATA_OUT <= rdata_d;
            INT_N_OUT <= int_n_d;
            TX_RDIL_OUT <= rdil_d;
            LOF_OUT <= (state_d == ST_LOF);
        end
    end

    // checks next to the logic they guard
    a_lof_hold_sef: assert property (
        in_lof && SEF_IN |=> in_lof ##0 LOF_OUT
    ) else $error("loss of frame cleared while SEF still present");

    a_thr_write: assert property (
        wr_stb && hit_thr |=> thr_q == $past(UP_WDATA_IN[THR_MSB:0])
    ) else $error("threshold write not taken from bits 3 to 0");

    a_count_gate: assert property (
        in_lof && SEF_IN |=> good_cnt_q == 4'h0
    ) else $error("good frames counted while SEF present");

    a_clear_at_thr: assert property (
        in_lof && !SEF_IN && good_cnt_q >= thr_q |=> !in_lof && !LOF_OUT
    ) else $error("loss of frame not cleared at threshold");

    a_status_read: assert property (
        rd_stb && hit_stat |=> UP_RDATA_OUT[BIT_LOF] == $past(in_lof)
                               && UP_RDATA_OUT[1] == $past(SEF_IN)
    ) else $error("defect status byte does not reflect defects");

    a_status_ro: assert property (
        wr_stb && hit_stat && !hit_thr |=> $stable(thr_q) && $stable(rdil_ctl_q)
    ) else $error("write to status byte changed a register");

    a_lof_int_set: assert property (
        $fell(in_lof) |-> int_flags[BIT_LOF] ##1 (!INT_N_OUT || !INT_EN_IN[BIT_LOF] || rd_int)
    ) else $error("clearance did not raise change-of-LOF interrupt");

    a_rur_clear: assert property (
        rd_int && int_ev == 8'h00 |=> int_flags == 8'h00
    ) else $error("interrupt status not cleared by read");

    a_rdil_follow: assert property (
        in_lof && rdil_ctl_q[CTL_RDIL_LOF] |=> TX_RDIL_OUT
    ) else $error("RDI-L not sent during loss of frame");

    a_rdil_gate: assert property (
        !rdil_ctl_q[CTL_RDIL_LOF] && !(rdil_ctl_q[CTL_RDIL_LOS] && LOS_IN) |=> !TX_RDIL_OUT
    ) else $error("RDI-L sent while disabled");

    a_lof_declare: assert property (
        in_sef_wait && SEF_IN && decl_done |=> in_lof ##0 int_flags[BIT_LOF]
    ) else $error("loss of frame not declared after SEF persisted");

    a_early_declare: assert property (
        $rose(in_lof) |-> $past(decl_cnt_q) == DECL_CNT_W'(LOF_DECL_CYC - 1)
    ) else $error("loss of frame declared before SEF time elapsed");

    a_ctl_upper_zero: assert property (
        rd_stb && hit_ctl |=> UP_RDATA_OUT[7:4] == 4'h0
    ) else $error("unused RDI-L control bits read nonzero");

    a_int_pin: assert property (
        (int_flags & INT_EN_IN) != 8'h00 |=> !INT_N_OUT
    ) else $error("interrupt pin not asserted with enabled flag pending");

    a_int_release: assert property (
        int_flags == 8'h00 |=> INT_N_OUT
    ) else $error("interrupt pin held with no pending flag");

    a_clear_needs_run: assert property (
        $fell(in_lof) |-> !$past(SEF_IN) && $past(good_cnt_q) >= $past(thr_q)
    ) else $error("loss of frame cleared without SEF gone and a full good run");

    a_thr_upper_zero: assert property (
        rd_stb && hit_thr |=> UP_RDATA_OUT[7:4] == 4'h0
    ) else $error("unused threshold bits read nonzero");

    a_bad_frame_zero: assert property (
        in_lof && FRAME_START_IN && !A1A2_OK_IN |=> good_cnt_q == 4'h0
    ) else $error("errored frame did not restart the good-frame run");

    a_good_frame_step: assert property (
        in_lof && !SEF_IN && FRAME_START_IN && A1A2_OK_IN && good_cnt_q < thr_q
        |=> good_cnt_q == $past(good_cnt_q) + 4'h1
    ) else $error("good frame not counted toward clearance");

    a_lof_bit_clear: assert property (
        clear_ok |=> !LOF_OUT && !status_byte[BIT_LOF]
    ) else $error("defect status LOF bit still set after clearance");

    a_status_live: assert property (
        rd_stb && hit_stat |=> UP_RDATA_OUT[0] == $past(LOS_IN) && UP_RDATA_OUT[7:3] ==
            $past({RDIL_DEF_IN, S1_UNSTABLE_IN, K1K2_UNSTABLE_IN, SF_IN, SD_IN})
    ) else $error("defect status byte does not show the defect levels");

    a_lof_chg_flag: assert property (
        clear_ok |=> int_flags[BIT_LOF] && !in_lof
    ) else $error("clearance did not set the change-of-LOF flag");

    a_int_read_data: assert property (
        rd_int |=> UP_RDATA_OUT == $past(int_flags)
    ) else $error("interrupt status read returned wrong flags");

    a_flag_set: assert property (
        int_ev != 8'h00 |=> (int_flags & $past(int_ev)) == $past(int_ev)
    ) else $error("interrupt event did not set its flag");

    a_rdil_idle: assert property (
        !in_lof && !(rdil_ctl_q[CTL_RDIL_LOS] && LOS_IN) |=> !TX_RDIL_OUT
    ) else $error("RDI-L sent with no enabled defect");

    a_no_decl_gap: assert property (
        in_sef_wait && !SEF_IN |=> !in_lof && decl_cnt_q == '0
    ) else $error("SEF break did not restart the declaration timer");

    a_ctl_write: assert property (
        wr_stb && hit_ctl |=> rdil_ctl_q == $past(UP_WDATA_IN[CTL_W-1:0])
    ) else $error("RDI-L control write not taken from bits 3 to 0");

    a_int_idle: assert property (
        (int_flags & INT_EN_IN) == 8'h00 |=> INT_N_OUT
    ) else $error("interrupt pin low with no enabled flag pending");
endmodule

// ==== logic/slc_pkg.sv ====
package slc_pkg;
    // microprocessor port geometry
    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;

    // register offsets
    localparam logic [15:0] ADDR_DEFECT_STAT0 = 16'h1107;
    localparam logic [15:0] ADDR_INT_STAT0 = 16'h110b;
    localparam logic [15:0] ADDR_INSYNC_THR = 16'h112b;
    localparam logic [15:0] ADDR_RDIL_CTRL = 16'h1933;

    // field positions
    localparam int THR_MSB = 3;
    localparam int THR_W = 4;
    localparam int BIT_LOF = 2;
    localparam int CTL_W = 4;
    localparam int CTL_RDIL_LOS = 0;
    localparam int CTL_RDIL_LOF = 1;

    // values after reset, and the value that unmapped reads return
    localparam logic [3:0] THR_RST = 4'h0;
    localparam logic [3:0] RDIL_CTRL_RST = 4'h2;
    localparam logic [7:0] RDATA_RST = 8'h00;
    localparam logic [7:0] UNMAPPED_DATA = 8'h00;

    // loss-of-frame declaration time: SEF must persist this long
    localparam int T_LOF_DECL_MS = 3;
    localparam int CLK_FREQ_KHZ = 50000;
    localparam int LOF_DECL_CYCLES = T_LOF_DECL_MS * CLK_FREQ_KHZ;
    localparam int DECL_CNT_W = 18;
    localparam logic [3:0] GOOD_CNT_MAX = 4'hf;

    // framing supervision states
    typedef enum logic [2:0] {
        ST_INFRAME = 3'b001,
        ST_SEF_WAIT = 3'b010,
        ST_LOF = 3'b100
    } slc_state_t;
endpackage

// ==== logic/slc_rur_flag.sv ====
`timescale 1ns/100ps
// sticky event flag, cleared by a read; a set in the clearing cycle wins
module slc_rur_flag (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic set_in,
    input wire logic clr_in,
    output logic q_out
);
    logic flag_d;

    // set has priority so an event landing on the read is not lost
    assign flag_d = set_in | (q_out & ~clr_in);

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            q_out <= 1'b0;
        end else begin
            q_out <= flag_d;
        end
    end
endmodule

// ==== test/slc_far_end.sv ====
`timescale 1ns/100ps
// far-end framer: one frame start every PERIOD cycles while enabled
module slc_far_end #(
    parameter int PERIOD = 5
) (
    input wire logic clk_in,
    input wire logic en_in,
    input wire logic ok_in,
    output logic frame_start_out,
    output logic a1a2_ok_out
);
    int cnt = 0;
    // qualifier toggles between frames so a stale level is never trusted
    initial begin
        frame_start_out = 1'b0;
        a1a2_ok_out = 1'b0;
    end
    always @(negedge clk_in) begin
        cnt = (cnt + 1) % PERIOD;
        frame_start_out <= en_in && cnt == 0;
        a1a2_ok_out <= (en_in && cnt == 0) ? ok_in : ~a1a2_ok_out;
    end
endmodule

// ==== test/sts3_lof_clear_and_rdil_auto_tb_top.sv ====
`timescale 1ns/100ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_errors++; \
    $display("Error t=%0t got %h exp %h", $time, g, e); end end
module sts3_lof_clear_and_rdil_auto_tb_top;
    import slc_pkg::*;
    localparam int DECL = 8;
    logic clk = 0, nrst = 0, sef = 0, fen = 0, fok = 1, cs_n = 1, rd_n = 1, wr_n = 1;
    logic [15:0] addr = '0;
    logic [7:0] wdata = '0, lv = '0, ev = '0, ev_s, ien = 8'hff, rd;
    logic [31:0] seed = 32'h64932ef8;
    wire fs, fq, int_n, tx_rdil, lof;
    wire [7:0] rdata;
    int n_errors = 0, num_checks = 0, cyc = 0;
    // clock and hang guard; the whole run needs well under 2000 cycles
    always #10 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            wrap_up();
        end
    end
    slc_far_end u_far (.clk_in(clk), .en_in(fen), .ok_in(fok), .frame_start_out(fs),
        .a1a2_ok_out(fq));
    slc_lof_top #(.LOF_DECL_CYC(DECL)) u_dut (.REF_CLK_IN(clk), .NRST_IN(nrst),
        .FRAME_START_IN(fs), .A1A2_OK_IN(fq), .SEF_IN(sef), .LOS_IN(lv[0]),
        .RDIL_DEF_IN(lv[7]), .S1_UNSTABLE_IN(lv[6]), .K1K2_UNSTABLE_IN(lv[5]),
        .SF_IN(lv[4]), .SD_IN(lv[3]), .SF_CHG_IN(ev[7]), .SD_CHG_IN(ev[6]),
        .REIL_ERR_IN(ev[5]), .B2_ERR_IN(ev[4]), .B1_ERR_IN(ev[3]), .SEF_CHG_IN(ev[1]),
        .LOS_CHG_IN(ev[0]), .INT_EN_IN(ien), .UP_CS_N_IN(cs_n), .UP_RD_N_IN(rd_n),
        .UP_WR_N_IN(wr_n), .UP_ADDR_IN(addr), .UP_WDATA_IN(wdata), .UP_RDATA_OUT(rdata),
        .INT_N_OUT(int_n), .TX_RDIL_OUT(tx_rdil), .LOF_OUT(lof));
    // bench helpers: random source and expected status byte
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [7:0] exp_stat(input logic [7:0] l, input logic f, s);
        return {l[7:3], f, s, l[0]};
    endfunction
    // one-cycle strobes only: a longer read would clear flags twice
    task automatic rd_reg(input logic [15:0] a);
        @(negedge clk);
        cs_n = 0;
        rd_n = 0;
        addr = a;
        @(negedge clk);
        cs_n = 1;
        rd_n = 1;
        rd = rdata;
    endtask
    task automatic chk_reg(input logic [15:0] a, input logic [7:0] e);
        rd_reg(a);
        `CHK(rd, e)
    endtask
    task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
        @(negedge clk);
        cs_n = 0;
        wr_n = 0;
        addr = a;
        wdata = d;
        @(negedge clk);
        cs_n = 1;
        wr_n = 1;
    endtask
    task automatic wait_frames(input int n);
        repeat (n) @(posedge clk iff fs);
        @(negedge clk);
    endtask
    task automatic wrap_up();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // main sequence
    initial begin
        repeat (16) @(negedge clk);
        nrst = 1;
        chk_reg(ADDR_RDIL_CTRL, 8'h02);
        chk_reg(ADDR_INSYNC_THR, 8'h00);
        chk_reg(16'h1200, 8'h00);
        wr_reg(ADDR_INSYNC_THR, 8'hf3);
        chk_reg(ADDR_INSYNC_THR, 8'h03);
        wr_reg(ADDR_DEFECT_STAT0, 8'hff);
        chk_reg(ADDR_DEFECT_STAT0, 8'h00);
        // random defect levels and one-cycle events
        for (int i = 0; i < 24; i++) begin
            seed = lfsr(seed);
            lv = seed[7:0] & 8'hf9;
            ev = seed[15:8] & 8'hfb;
            ev_s = ev;
            @(negedge clk);
            ev = 8'h00;
            chk_reg(ADDR_DEFECT_STAT0, exp_stat(lv, 1'b0, 1'b0));
            `CHK(int_n, ev_s == 8'h00)
            chk_reg(ADDR_INT_STAT0, ev_s);
            chk_reg(ADDR_INT_STAT0, 8'h00);
            `CHK(int_n, 1'b1)
        end
        // declaration with the interrupt masked, then unmasked
        lv = 8'h00;
        ien = 8'h00;
        sef = 1;
        repeat (DECL - 1) @(negedge clk);
        `CHK(lof, 1'b0)
        repeat (5) @(negedge clk);
        `CHK(lof, 1'b1)
        `CHK(tx_rdil, 1'b1)
        `CHK(int_n, 1'b1)
        ien = 8'hff;
        repeat (2) @(negedge clk);
        `CHK(int_n, 1'b0)
        chk_reg(ADDR_INT_STAT0, 8'h04);
        chk_reg(ADDR_DEFECT_STAT0, 8'h06);
        // good frames during SEF must not count
        fen = 1;
        wait_frames(4);
        fen = 0;
        sef = 0;
        repeat (12) @(negedge clk);
        `CHK(lof, 1'b1)
        // a bad frame restarts the run of three
        fen = 1;
        wait_frames(2);
        fok = 0;
        wait_frames(1);
        fok = 1;
        wait_frames(2);
        `CHK(lof, 1'b1)
        `CHK(tx_rdil, 1'b1)
        // the frame that completes the run is seen on one edge, LOF drops on the next
        wait_frames(1);
        @(negedge clk);
        `CHK(lof, 1'b0)
        fen = 0;
        @(negedge clk);
        `CHK(int_n, 1'b0)
        `CHK(tx_rdil, 1'b0)
        chk_reg(ADDR_DEFECT_STAT0, 8'h00);
        chk_reg(ADDR_INT_STAT0, 8'h04);
        chk_reg(ADDR_INT_STAT0, 8'h00);
        `CHK(int_n, 1'b1)
        // automatic RDI-L disabled, then enabled in mid-defect
        wr_reg(ADDR_RDIL_CTRL, 8'hfc);
        chk_reg(ADDR_RDIL_CTRL, 8'h0c);
        sef = 1;
        repeat (DECL + 4) @(negedge clk);
        `CHK(lof, 1'b1)
        `CHK(tx_rdil, 1'b0)
        wr_reg(ADDR_RDIL_CTRL, 8'h02);
        @(negedge clk);
        `CHK(tx_rdil, 1'b1)
        wr_reg(ADDR_INSYNC_THR, 8'h00);
        sef = 0;
        repeat (3) @(negedge clk);
        `CHK(lof, 1'b0)
        `CHK(tx_rdil, 1'b0)
        // RDI-L on LOS alone, and an SEF burst too short to declare
        wr_reg(ADDR_RDIL_CTRL, 8'h01);
        lv = 8'h01;
        sef = 1;
        repeat (DECL - 2) @(negedge clk);
        sef = 0;
        repeat (3) @(negedge clk);
        `CHK(lof, 1'b0)
        `CHK(tx_rdil, 1'b1)
        chk_reg(ADDR_DEFECT_STAT0, 8'h01);
        // reset in mid-run returns registers and outputs to their idle values
        lv = 8'h00;
        nrst = 0;
        repeat (2) @(negedge clk);
        `CHK(tx_rdil, 1'b0)
        `CHK(int_n, 1'b1)
        nrst = 1;
        chk_reg(ADDR_RDIL_CTRL, 8'h02);
        chk_reg(ADDR_INSYNC_THR, 8'h00);
        chk_reg(ADDR_INT_STAT0, 8'h00);
        `CHK(lof, 1'b0)
        wrap_up();
    end
endmodule
